// File: rtl/sli_pkg.sv
// Package for the sync line indirect register bank
package sli_pkg;
   localparam int SLI_PTR_W = 4;
   localparam int SLI_WORD_W = 16;
   localparam int SLI_NUM_REGS = 16;
   // Indirect register indexes
   localparam logic [3:0] SLI_IDX_PROTO = 4'h0;
   localparam logic [3:0] SLI_IDX_RXERR = 4'h1;
   localparam logic [3:0] SLI_IDX_TXERR = 4'h2;
   localparam logic [3:0] SLI_IDX_MODEM = 4'h4;
   localparam logic [3:0] SLI_IDX_UNUSED = 4'hF;
   // Writable bit masks per register
   localparam logic [15:0] SLI_MASK_PROTO = 16'hE77F;
   localparam logic [15:0] SLI_MASK_RXERR = 16'h0000;
   localparam logic [15:0] SLI_MASK_TXERR = 16'h0F00;
   localparam logic [15:0] SLI_MASK_SYNC = 16'hFF1F;
   localparam logic [15:0] SLI_MASK_MODEM = 16'h1700;
   localparam logic [15:0] SLI_MASK_FULL = 16'hFFFF;
   localparam logic [15:0] SLI_MASK_COUNT = 16'h3FFF;
   localparam logic [15:0] SLI_MASK_MATCH = 16'h00FF;
   localparam logic [15:0] SLI_MASK_NONE = 16'h0000;
   localparam logic [7:0] SLI_MODEM_IN_MASK = 8'hF4;
   localparam logic [7:0] SLI_ERR_MASK = 8'h7E;
   localparam logic [7:0] SLI_TXERR_MASK = 8'h07;
   // Field positions in register 0
   localparam int SLI_ERRCTL_LSB = 0;
   localparam int SLI_PROTO_LSB = 3;
   localparam int SLI_STRIP_BIT = 6;
   localparam int SLI_RXBPC_LSB = 8;
   localparam int SLI_TXBPC_LSB = 13;
   // Receive error bit positions
   localparam int SLI_E_OVERRUN = 1;
   localparam int SLI_E_DMA = 2;
   localparam int SLI_E_BLOCK = 3;
   localparam int SLI_E_PARITY = 4;
   localparam int SLI_E_ABORT = 5;
   localparam int SLI_E_OVERFLOW = 6;
   localparam logic [2:0] SLI_BPC_EIGHT = 3'h0;
   localparam logic [3:0] SLI_BPC_FULL = 4'h8;

   typedef enum logic [2:0] {
      SLI_CHK_CCITT_ONES = 3'h0,
      SLI_CHK_CCITT_ZEROS = 3'h1,
      SLI_CHK_BLKCHR_ODD = 3'h2,
      SLI_CHK_CRC16 = 3'h3,
      SLI_CHK_BLK_ODD = 3'h4,
      SLI_CHK_BLK_EVEN = 3'h5,
      SLI_CHK_BLKCHR_EVEN = 3'h6,
      SLI_CHK_NONE = 3'h7
   } sli_check_type;

   typedef enum logic [2:0] {
      SLI_PR_COUNT = 3'h0,
      SLI_PR_SDLC = 3'h1,
      SLI_PR_HDLC = 3'h2,
      SLI_PR_SPARE3 = 3'h3,
      SLI_PR_SPARE4 = 3'h4,
      SLI_PR_SPARE5 = 3'h5,
      SLI_PR_SPARE6 = 3'h6,
      SLI_PR_GENBYTE = 3'h7
   } sli_proto_type;

   // Host access to the pointer and data port
   typedef struct packed {
      logic ptr_wr;
      logic [3:0] ptr_data;
      logic data_wr;
      logic data_rd;
      logic [15:0] data;
   } sli_host_req_type;

   // Receive engine events, one-cycle pulses
   typedef struct packed {
      logic overrun;
      logic dma_timeout;
      logic block_fail;
      logic parity_fail;
      logic seven_ones;
      logic count_zero_more;
      logic residual_a_wr;
      logic residual_b_wr;
      logic [2:0] residual;
   } sli_rx_event_type;

   typedef struct packed {
      logic [2:0] error_check;
      logic [2:0] protocol;
      logic strip_sync;
      logic sync_removal;
      logic bit_oriented;
      logic [3:0] rx_bits;
      logic [3:0] tx_bits;
   } sli_config_type;

   // Decode bits per character code
   function automatic logic [3:0] sli_bpc(input logic [2:0] code);
      sli_bpc = (code == SLI_BPC_EIGHT) ? SLI_BPC_FULL : {1'b0, code};
   endfunction
endpackage

// File: rtl/sli_indirect_regs.sv
// Indirect register bank and receive status of a sync line interface
//
// What this block does
// - 4-bit pointer selects one of sixteen registers
// - Each data port write advances pointer; a pointer write in the same cycle wins
// - Pointer write or increment reloads read cache
// - Resets clear receive errors and register two
// - Bus init alone clears modem register
// - Per-register write masks; registers 1 and 15 are not writable
// - Bits 2:0 select error control scheme
// - Bits 5:3 select protocol, others spare
// - Strip sync bit matters in general mode
// - Receive length: code zero means eight bits
// - Transmit length uses same encoding
// - Bit 1 flags receive overrun
// - Bit 2 flags DMA timeout, drops enable
// - Bit 3 flags block check failure
// - Bit 4 flags parity, byte protocols only
// - Bit 5 flags abort, bit protocols active
// - Bit 6 flags overflow, never general mode
// - Secondary residual count, nonzero sets status
// - Primary residual count, nonzero sets status
// - Modem byte read clears change flags
`timescale 1ns/1ps
`default_nettype none
module sli_indirect_regs (
   // Clock and resets
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic master_reset_in,
   input wire logic bus_init_in,
   // Host access
   input wire sli_pkg::sli_host_req_type host_in,
   output logic [15:0] read_data_out,
   output logic [3:0] pointer_out,
   // Receive engine
   input wire sli_pkg::sli_rx_event_type rx_event_in,
   input wire logic rx_active_in,
   input wire logic rx_enable_set_in,
   input wire logic [2:0] tx_error_set_in,
   input wire logic [7:0] modem_lines_in,
   // Status and configuration
   output logic rx_enable_out,
   output logic residual_b_nonzero_out,
   output logic residual_a_nonzero_out,
   output logic modem_change_out,
   output logic [7:0] modem_change_flags_out,
   output sli_pkg::sli_config_type config_out,
   output logic [15:0] reg_word_out [16]
);
   import sli_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [15:0] regs_reg [SLI_NUM_REGS];
   logic [15:0] regs_next [SLI_NUM_REGS];
   logic [3:0] ptr_reg;
   logic [15:0] cache_reg;
   logic rx_enable_reg;
   logic [7:0] modem_in_reg;
   logic [7:0] change_reg;
   logic rd_clear_reg;
   logic rd_modem_reg;
   sli_config_type config_reg;

   function automatic logic [15:0] wr_mask(input logic [3:0] idx);
      unique case (idx)
         4'h0: wr_mask = SLI_MASK_PROTO;
         4'h1: wr_mask = SLI_MASK_RXERR;
         4'h2: wr_mask = SLI_MASK_TXERR;
         4'h3: wr_mask = SLI_MASK_SYNC;
         4'h4: wr_mask = SLI_MASK_MODEM;
         4'h5, 4'h6, 4'h8, 4'hA, 4'hC: wr_mask = SLI_MASK_FULL;
         4'h7, 4'h9, 4'hB, 4'hD: wr_mask = SLI_MASK_COUNT;
         4'hE: wr_mask = SLI_MASK_MATCH;
         4'hF: wr_mask = SLI_MASK_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   wire logic any_reset = master_reset_in | bus_init_in;
   wire logic [3:0] ptr_adv = ptr_reg + 4'h1;
   wire logic [3:0] ptr_next = host_in.ptr_wr ? host_in.ptr_data :
      (host_in.data_wr ? ptr_adv : ptr_reg);
   wire logic [15:0] sel_mask = wr_mask(ptr_reg);
   wire logic [15:0] wr_word = (regs_reg[ptr_reg] & ~sel_mask) |
      (host_in.data & sel_mask);
   wire logic [2:0] proto_code = regs_reg[SLI_IDX_PROTO][SLI_PROTO_LSB +: 3];
   wire logic is_general = proto_code == SLI_PR_GENBYTE;
   wire logic is_bitproto = (proto_code == SLI_PR_SDLC) ||
      (proto_code == SLI_PR_HDLC);
   wire logic is_byteproto = is_general || (proto_code == SLI_PR_COUNT);
   // Reads clear after the cached word is returned
   wire logic rd_err = host_in.data_rd && !host_in.data_wr;
   wire logic [7:0] modem_change_now = (modem_lines_in ^ modem_in_reg) &
      SLI_MODEM_IN_MASK;

   // Receive error set terms
   logic [7:0] err_set;
   always_comb begin
      err_set = 8'h00;
      err_set[SLI_E_OVERRUN] = rx_event_in.overrun;
      err_set[SLI_E_DMA] = rx_event_in.dma_timeout;
      err_set[SLI_E_BLOCK] = rx_event_in.block_fail;
      err_set[SLI_E_PARITY] = rx_event_in.parity_fail && is_byteproto;
      err_set[SLI_E_ABORT] = rx_event_in.seven_ones && is_bitproto &&
         rx_active_in;
      err_set[SLI_E_OVERFLOW] = rx_event_in.count_zero_more && !is_general;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next register values
   always_comb begin
      for (int i = 0; i < SLI_NUM_REGS; i++) begin
         regs_next[i] = regs_reg[i];
      end
      if (host_in.data_wr) begin
         regs_next[ptr_reg] = wr_word;
      end
      if (rd_clear_reg && ptr_reg == SLI_IDX_RXERR) begin
         regs_next[SLI_IDX_RXERR][7:0] = 8'h00;
      end
      if (rd_clear_reg && ptr_reg == SLI_IDX_TXERR) begin
         regs_next[SLI_IDX_TXERR][7:0] = 8'h00;
      end
      regs_next[SLI_IDX_RXERR][7:0] = (regs_next[SLI_IDX_RXERR][7:0] |
         err_set) & SLI_ERR_MASK;
      regs_next[SLI_IDX_TXERR][7:0] = (regs_next[SLI_IDX_TXERR][7:0] |
         {5'h00, tx_error_set_in}) & SLI_TXERR_MASK;
      if (rx_event_in.residual_b_wr && is_bitproto) begin
         regs_next[SLI_IDX_RXERR][10:8] = rx_event_in.residual;
      end
      if (rx_event_in.residual_a_wr && is_bitproto) begin
         regs_next[SLI_IDX_RXERR][14:12] = rx_event_in.residual;
      end
      regs_next[SLI_IDX_MODEM][7:0] = modem_lines_in & SLI_MODEM_IN_MASK;
      regs_next[SLI_IDX_UNUSED] = 16'h0000;
      if (any_reset) begin
         regs_next[SLI_IDX_RXERR][7:0] = 8'h00;
         regs_next[SLI_IDX_TXERR] = 16'h0000;
      end
      if (bus_init_in) begin
         regs_next[SLI_IDX_MODEM] = {8'h00, modem_lines_in &
            SLI_MODEM_IN_MASK};
      end
   end

   // Decoded configuration
   sli_config_type config_next;
   always_comb begin
      config_next.error_check = regs_reg[SLI_IDX_PROTO][SLI_ERRCTL_LSB +: 3];
      config_next.protocol = proto_code;
      config_next.strip_sync = regs_reg[SLI_IDX_PROTO][SLI_STRIP_BIT];
      config_next.sync_removal = is_general ?
         regs_reg[SLI_IDX_PROTO][SLI_STRIP_BIT] : 1'b1;
      config_next.bit_oriented = is_bitproto;
      config_next.rx_bits = sli_bpc(regs_reg[SLI_IDX_PROTO][SLI_RXBPC_LSB +: 3]);
      config_next.tx_bits = sli_bpc(regs_reg[SLI_IDX_PROTO][SLI_TXBPC_LSB +: 3]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < SLI_NUM_REGS; i++) begin
            regs_reg[i] <= 16'h0000;
         end
      end else begin
         regs_reg <= regs_next;
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ptr_reg <= 4'h0;
         cache_reg <= 16'h0000;
      end else begin
         ptr_reg <= ptr_next;
         if (host_in.ptr_wr || host_in.data_wr) begin
            cache_reg <= (host_in.data_wr && ptr_next == ptr_reg) ?
               wr_word : regs_reg[ptr_next];
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_clear_reg <= 1'b0;
         rd_modem_reg <= 1'b0;
      end else begin
         rd_clear_reg <= rd_err;
         rd_modem_reg <= rd_err && ptr_reg == SLI_IDX_MODEM;
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rx_enable_reg <= 1'b0;
      end else if (any_reset || rx_event_in.dma_timeout) begin
         rx_enable_reg <= 1'b0;
      end else if (rx_enable_set_in) begin
         rx_enable_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         modem_in_reg <= 8'h00;
         change_reg <= 8'h00;
      end else begin
         modem_in_reg <= modem_lines_in & SLI_MODEM_IN_MASK;
         if (any_reset) begin
            change_reg <= 8'h00;
         end else if (rd_modem_reg) begin
            change_reg <= modem_change_now;
         end else begin
            change_reg <= change_reg | modem_change_now;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         read_data_out <= 16'h0000;
         pointer_out <= 4'h0;
         rx_enable_out <= 1'b0;
         residual_b_nonzero_out <= 1'b0;
         residual_a_nonzero_out <= 1'b0;
         modem_change_out <= 1'b0;
         modem_change_flags_out <= 8'h00;
         config_out <= '0;
         for (int i = 0; i < SLI_NUM_REGS; i++) begin
            reg_word_out[i] <= 16'h0000;
         end
      end else begin
         read_data_out <= cache_reg;
         pointer_out <= ptr_next;
         rx_enable_out <= rx_enable_reg;
         residual_b_nonzero_out <= |regs_reg[SLI_IDX_RXERR][10:8];
         residual_a_nonzero_out <= |regs_reg[SLI_IDX_RXERR][14:12];
         modem_change_out <= |change_reg;
         modem_change_flags_out <= change_reg;
         config_out <= config_next;
         reg_word_out <= regs_reg;
      end
   end
endmodule
`default_nettype wire

// File: verif/sli_indirect_regs_assertions.sv
// Port assertions for the indirect register bank
`timescale 1ns/1ps
`default_nettype none
module sli_indirect_regs_assertions (
   // Clock and resets
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic master_reset_in,
   input wire logic bus_init_in,
   // Host side
   input wire sli_pkg::sli_host_req_type host_in,
   input wire logic [15:0] read_data_out,
   input wire logic [3:0] pointer_out,
   // Receive side and status
   input wire sli_pkg::sli_rx_event_type rx_event_in,
   input wire logic rx_enable_set_in,
   input wire logic [2:0] tx_error_set_in,
   input wire logic rx_enable_out,
   input wire logic residual_a_nonzero_out,
   input wire logic [15:0] reg_word_out [16]
);
   import sli_pkg::*;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   wire logic quiet;
   assign quiet = !host_in.ptr_wr && !host_in.data_wr && !master_reset_in
      && !bus_init_in;
   property p_ptr_load;
      host_in.ptr_wr |=> pointer_out == $past(host_in.ptr_data);
   endproperty
   a_ptr_load: assert property (p_ptr_load)
      else $error("pointer load wrong");
   property p_ptr_inc;
      host_in.data_wr && !host_in.ptr_wr
         |=> pointer_out == $past(pointer_out) + 4'h1;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc)
      else $error("pointer did not advance");
   property p_cache_hold;
      quiet [*3] |-> $stable(read_data_out);
   endproperty
   a_cache_hold: assert property (p_cache_hold)
      else $error("read data moved without pointer change");
   property p_rx_en_drop;
      rx_event_in.dma_timeout && !rx_enable_set_in |=> ##1 !rx_enable_out;
   endproperty
   a_rx_en_drop: assert property (p_rx_en_drop)
      else $error("receiver enable kept after bus timeout");
   property p_residual;
      $stable(reg_word_out[1])
         |-> residual_a_nonzero_out == (reg_word_out[1][14:12] != 3'h0);
   endproperty
   a_residual: assert property (p_residual)
      else $error("primary residual status wrong");
   property p_unused;
      reg_word_out[15] == 16'h0000 && reg_word_out[1][7] == 1'b0
         && reg_word_out[1][0] == 1'b0;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused bit not zero");
   property p_resets;
      (master_reset_in || bus_init_in) && rx_event_in == '0
         && tx_error_set_in == 3'h0 && !host_in.data_wr
         |=> ##1 reg_word_out[1][7:0] == 8'h00
         && reg_word_out[2] == 16'h0000;
   endproperty
   a_resets: assert property (p_resets)
      else $error("reset left error bytes set");
   property p_rd_clear;
      host_in.data_rd && !host_in.data_wr && !host_in.ptr_wr
         && pointer_out == SLI_IDX_RXERR && rx_event_in == '0
         ##1 rx_event_in == '0 |=> ##1 reg_word_out[1][7:0] == 8'h00;
   endproperty
   a_rd_clear: assert property (p_rd_clear)
      else $error("receive errors not cleared by read");
   c_write: cover property (host_in.data_wr);
   c_timeout: cover property (rx_event_in.dma_timeout);
   c_init: cover property (bus_init_in);
endmodule
`default_nettype wire

// File: verif/sli_host_model.sv
// Host software model driving the pointer and data port
`timescale 1ns/1ps
`default_nettype none
module sli_host_model (
   // Clock
   input wire logic clk_sys_in,
   // Host port
   output var sli_pkg::sli_host_req_type host_out,
   input wire logic [15:0] read_data_in
);
   import sli_pkg::*;
   initial host_out = '0;
   // One strobe cycle, k is ptr_wr, data_wr, data_rd
   task automatic op(input logic [2:0] k, input logic [15:0] d);
      @(negedge clk_sys_in);
      host_out = '{k[2], d[3:0], k[1], k[0], d};
      @(negedge clk_sys_in);
      host_out = '0;
   endtask
   task automatic rd(input logic [3:0] idx, output logic [15:0] v);
      op(3'h4, {12'h000, idx});
      repeat (3) @(negedge clk_sys_in);
      v = read_data_in;
      op(3'h1, 16'h0000);
   endtask
endmodule
`default_nettype wire

// File: verif/sli_indirect_regs_bench.sv
// Self-checking bench for the indirect register bank
`timescale 1ns/1ps
`default_nettype none
module sli_indirect_regs_bench;
   import sli_pkg::*;
   logic clk_sys_in, reset_n_in, master_reset_in, bus_init_in;
   sli_host_req_type host_in;
   sli_rx_event_type rx_event_in;
   logic rx_active_in, rx_enable_set_in, rx_enable_out, res_a, res_b, mchg;
   logic [2:0] tx_error_set_in, k;
   logic [3:0] pointer_out, b;
   logic [7:0] modem_lines_in, flags;
   logic [15:0] read_data_out, v;
   sli_config_type config_out;
   logic [15:0] reg_word_out [16];
   logic [15:0] cfg [3] = '{16'h0003, 16'h0008, 16'h003F};
   logic [7:0] err [3] = '{8'h5E, 8'h6E, 8'h1E};
   // Residual byte seen per protocol; byte protocols keep the old value
   logic [7:0] hi [3] = '{8'h00, 8'h55, 8'h55};
   int failures = 0;
   int n_checks = 0;
   sli_host_model host (.clk_sys_in, .host_out(host_in),
      .read_data_in(read_data_out));
   sli_indirect_regs DUT (.clk_sys_in, .reset_n_in, .master_reset_in,
      .bus_init_in, .host_in, .read_data_out, .pointer_out, .rx_event_in,
      .rx_active_in, .rx_enable_set_in, .tx_error_set_in, .modem_lines_in,
      .rx_enable_out, .residual_b_nonzero_out(res_b),
      .residual_a_nonzero_out(res_a), .modem_change_out(mchg),
      .modem_change_flags_out(flags), .config_out, .reg_word_out);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
         input string what);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic wait3;
      repeat (3) @(negedge clk_sys_in);
   endtask
   task automatic ev(input logic [10:0] e);
      @(negedge clk_sys_in);
      rx_event_in = sli_rx_event_type'(e);
      @(negedge clk_sys_in);
      rx_event_in = '0;
   endtask
   task automatic sync_rst(input logic init);
      @(negedge clk_sys_in);
      {bus_init_in, master_reset_in} = {init, !init};
      @(negedge clk_sys_in);
      {bus_init_in, master_reset_in} = 2'b00;
      wait3;
   endtask
   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      repeat (5000) @(posedge clk_sys_in);
      failures++;
      complete_run;
   end
   initial begin
      {reset_n_in, master_reset_in, bus_init_in} = 3'h0;
      {rx_active_in, rx_enable_set_in, tx_error_set_in} = 5'h00;
      rx_event_in = '0;
      modem_lines_in = 8'h00;
      repeat (6) @(negedge clk_sys_in);
      reset_n_in = 1'b1;
      host.op(3'h4, 16'h0000);
      for (int i = 0; i < 4; i++) host.op(3'h2, 16'hFFFF);
      wait3;
      chk(pointer_out, 16'h0004, "pointer");
      host.rd(SLI_IDX_PROTO, v);
      chk(v, SLI_MASK_PROTO, "reg0");
      host.rd(4'h3, v);
      chk(v, SLI_MASK_SYNC, "reg3");
      host.rd(4'h3, v);
      chk(v, SLI_MASK_SYNC, "reg3 again");
      host.op(3'h4, 16'h000F);
      host.op(3'h2, 16'hFFFF);
      wait3;
      chk(pointer_out, 16'h0000, "wrap");
      host.rd(SLI_IDX_UNUSED, v);
      chk(v, 16'h0000, "reg15");
      for (int c = 0; c < 16; c++) begin
         k = c[2:0];
         b = (k == 3'h0) ? 4'h8 : {1'b0, k};
         host.op(3'h4, 16'h0000);
         host.op(3'h2, {k, 2'b00, k, 1'b0, c[3], k, k});
         wait3;
         chk(config_out.error_check, k, "errctl");
         chk(config_out.protocol, k, "proto");
         chk(config_out.rx_bits, b, "rx bits");
         chk(config_out.tx_bits, b, "tx bits");
         chk(config_out.sync_removal, k != 3'h7 || c[3], "sync");
         chk(config_out.strip_sync, c[3], "strip");
         chk(config_out.bit_oriented, k == 3'h1 || k == 3'h2,
            "bitp");
      end
      rx_active_in = 1'b1;
      for (int p = 0; p < 3; p++) begin
         host.op(3'h4, 16'h0000);
         host.op(3'h2, cfg[p]);
         @(negedge clk_sys_in);
         rx_enable_set_in = 1'b1;
         @(negedge clk_sys_in);
         rx_enable_set_in = 1'b0;
         wait3;
         chk(rx_enable_out, 16'h0001, "rx enable");
         ev(11'h7FD);
         wait3;
         chk(rx_enable_out, 16'h0000, "rx drop");
         chk({res_a, res_b}, {2{hi[p] != 8'h00}}, "res st");
         host.rd(SLI_IDX_RXERR, v);
         chk(v[7:0], err[p], "rx err");
         chk(v[6], err[p][6], "overflow");
         chk(v[15:8], hi[p], "residual");
         host.rd(SLI_IDX_RXERR, v);
         chk(v, {hi[p], 8'h00}, "after read");
      end
      modem_lines_in = 8'hFF;
      wait3;
      chk(flags, SLI_MODEM_IN_MASK, "change flags");
      chk(mchg, 16'h0001, "change out");
      host.op(3'h4, 16'h0004);
      host.op(3'h2, 16'hFFFF);
      host.rd(SLI_IDX_MODEM, v);
      chk(v, {SLI_MASK_MODEM[15:8], SLI_MODEM_IN_MASK}, "reg4");
      wait3;
      chk(flags, 16'h0000, "flags read");
      chk(mchg, 16'h0000, "change clr");
      tx_error_set_in = 3'h7;
      ev(11'h400);
      tx_error_set_in = 3'h0;
      sync_rst(1'b0);
      chk(reg_word_out[2], 16'h0000, "reg2");
      chk(reg_word_out[1], 16'h5500, "reg1");
      chk(reg_word_out[4][15:8], SLI_MASK_MODEM[15:8], "modem out");
      sync_rst(1'b1);
      chk(reg_word_out[4][15:8], 16'h0000, "modem init");
      complete_run;
   end
endmodule
bind sli_indirect_regs sli_indirect_regs_assertions chk_i (.clk_sys_in,
   .reset_n_in, .master_reset_in, .bus_init_in, .host_in, .read_data_out,
   .pointer_out, .rx_event_in, .rx_enable_set_in, .tx_error_set_in,
   .rx_enable_out, .residual_a_nonzero_out, .reg_word_out);
`default_nettype wire
